/* File: hdl/psp_consts.svh */
// Purpose: register offsets, field positions and reset values of the parallel slave port
// Assumes: apb byte addresses equal to four times the printed register index
// Notes: included by its bare name
`ifndef PSP_CONSTS_SVH
`define PSP_CONSTS_SVH
`define IDX_DATA_LATCH 8'h08
`define IDX_STROBE_PINS 8'h09
`define IDX_CORE_IRQ_CTRL 8'h0b
`define IDX_IRQ_FLAGS 8'h0c
`define IDX_DIR_STATUS 8'h89
`define IDX_DATA_DIR 8'h88
`define IDX_IRQ_ENABLES 8'h8c
`define IDX_ANALOG_CFG 8'h9f
`define BIT_IN_FULL 7
`define BIT_OUT_FULL 6
`define BIT_OVERRUN 5
`define BIT_MODE 4
`define BIT_PORT_IRQ 7
`define RST_DIR_STATUS 8'h07
`define RST_IRQ_FLAGS 8'h00
`define RST_IRQ_ENABLES 8'h00
`define RST_ANALOG_CFG 8'h00
`define RST_CORE_IRQ_CTRL 8'h00
`define RST_DATA_DIR 8'hff
`define DIGITAL_CFG 3'h7
`define PHASE_COUNT 2'h3
`define PHASE_Q2 2'h1
`define PHASE_Q4 2'h3
`endif

/* File: hdl/psp_pkg.sv */
// Purpose: shared types of the parallel slave port
// Assumes: nothing beyond the constants header
// Notes: strobe bundle carries the three active-low controls
package psp_pkg;
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } strobe_t;
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_WRITE,
      ACC_READ
   } access_t;
endpackage : psp_pkg

/* File: hdl/strobe_sync.sv */
// Purpose: three-flop synchroniser for the external strobes
// Assumes: strobes idle high
// Notes: a change counts once stages two and three agree
`timescale 1ns/10ps
module strobe_sync
   import psp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // strobes
   input wire strobe_t raw,
   output strobe_t clean
);
   strobe_t s1_r;
   strobe_t s2_r;
   strobe_t s3_r;
   strobe_t clean_r;
   wire agree = (s2_r == s3_r);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 3'h7;
         s2_r <= 3'h7;
         s3_r <= 3'h7;
         clean_r <= 3'h7;
      end else begin
         s1_r <= raw; // RULE21
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            clean_r <= s3_r;
         end
      end
   end
   assign clean = clean_r;
endmodule : strobe_sync

/* File: hdl/phase_gen.sv */
// Purpose: four-phase core cycle generator
// Assumes: one phase per pclk
// Notes: q2 and q4 are one-cycle enables
`timescale 1ns/10ps
`include "psp_consts.svh"
module phase_gen (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // phases
   output logic q2,
   output logic q4
);
   logic [1:0] ph_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_r <= 2'h0;
      end else begin
         ph_r <= ph_r + 2'h1;
      end
   end
   assign q2 = (ph_r == `PHASE_Q2);
   assign q4 = (ph_r == `PHASE_Q4);
endmodule : phase_gen

/* File: hdl/parallel_slave_port.sv */
// Purpose: 8-bit parallel slave port with apb register access
// Assumes: strobes asynchronous to pclk; apb master holds requests until pready
// Notes: zero-wait apb slave; unmapped addresses read zero and never error
`timescale 1ns/10ps
`include "psp_consts.svh"
// Operation
// RULE1: mode bit selects slave port or gpio
// RULE2: control pins become read, write, select
// RULE3: strobe pins must be digital inputs
// RULE4: separate in and out latches, one address
// RULE5: data direction ignored in port mode
// RULE6: external access accepted at any time
// RULE7: write starts on select and write low
// RULE8: write end sets input full at q4
// RULE9: write end sets port interrupt flag
// RULE10: only cpu read clears input full
// RULE11: second unread write sets overrun
// RULE12: overrun cleared only by software zero
// RULE13: read start drives data, clears out full
// RULE14: read end sets port interrupt flag
// RULE15: cpu write sets out full
// RULE16: flags held zero outside port mode; the code holds input full and output full at zero, overrun keeps its value
// RULE17: flag latched; irq only when enabled
// RULE18: direction bit one input, zero output
// RULE19: reset gives status zero, direction ones
// RULE20: chip select is active low
// RULE21: strobes synchronised before edge detection
module parallel_slave_port
   import psp_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // data pins
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic [7:0] data_oe_n,
   // strobe pins
   input wire logic read_strobe_pin,
   input wire logic write_strobe_pin,
   input wire logic chip_select_pin,
   output logic [2:0] strobe_out,
   output logic [2:0] strobe_oe_n,
   // interrupt request to the core
   output logic port_irq
);
   // registers
   logic [7:0] out_latch_r;
   logic [7:0] in_latch_r;
   logic [7:0] pin_latch_r;
   logic [2:0] strobe_latch_r;
   logic [7:0] data_dir_r;
   logic [2:0] strobe_dir_bits_r;
   logic psp_mode_select_r;
   logic in_buf_full_r;
   logic out_buf_full_r;
   logic in_buf_overrun_r;
   logic [7:0] irq_flags_r;
   logic [7:0] irq_en_r;
   logic [7:0] core_irq_r;
   logic [2:0] analog_cfg_field_r;
   logic [31:0] prdata_r;
   logic port_irq_r;
   logic [7:0] data_out_r;
   logic [7:0] data_oe_n_r;
   logic [2:0] strobe_out_r;
   logic [2:0] strobe_oe_n_r;
   access_t acc_r;
   logic end_pend_r;
   logic end_q2_r;
   logic end_write_r;
   logic q2;
   logic q4;
   strobe_t raw;
   strobe_t clean;

   function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
      hit = (a == {22'h0, idx, 2'h0});
   endfunction : hit

   assign raw = '{cs_n: chip_select_pin, wr_n: write_strobe_pin, rd_n: read_strobe_pin};

   strobe_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .raw(raw),
      .clean(clean)
   );

   phase_gen u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .q2(q2),
      .q4(q4)
   );

   // apb decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_data = hit(paddr, `IDX_DATA_LATCH);
   wire hit_pins = hit(paddr, `IDX_STROBE_PINS);
   wire hit_core = hit(paddr, `IDX_CORE_IRQ_CTRL);
   wire hit_flags = hit(paddr, `IDX_IRQ_FLAGS);
   wire hit_dir = hit(paddr, `IDX_DIR_STATUS);
   wire hit_ddir = hit(paddr, `IDX_DATA_DIR);
   wire hit_en = hit(paddr, `IDX_IRQ_ENABLES);
   wire hit_adc = hit(paddr, `IDX_ANALOG_CFG);
   wire cpu_wr_data = wr & hit_data;
   wire cpu_rd_data = rd & hit_data;

   // strobe function needs port mode plus digital input configuration
   wire mode = psp_mode_select_r; // RULE1
   wire digital = (analog_cfg_field_r == `DIGITAL_CFG);
   wire strobes_ok = mode & digital & (&strobe_dir_bits_r); // RULE3
   // select is active low
   wire sel = ~clean.cs_n; // RULE20
   wire wr_active = strobes_ok & sel & ~clean.wr_n; // RULE2 RULE6 RULE7
   wire rd_active = strobes_ok & sel & ~clean.rd_n; // RULE2 RULE13
   wire rd_start = rd_active & (acc_r == ACC_IDLE);
   wire wr_start = wr_active & (acc_r == ACC_IDLE);
   wire acc_end = ((acc_r == ACC_WRITE) & ~wr_active) | ((acc_r == ACC_READ) & ~rd_active);
   wire flag_evt = end_q2_r & q4; // RULE8 RULE14
   wire set_ibf = flag_evt & end_write_r & mode;
   wire set_ovr = set_ibf & in_buf_full_r & ~cpu_rd_data; // RULE11

   // pin read values: analog-configured strobe pins read zero
   wire [2:0] strobe_pin_val = digital ? clean : 3'h0;
   wire [7:0] dir_status = {in_buf_full_r, out_buf_full_r, in_buf_overrun_r,
                            psp_mode_select_r, 1'b0, strobe_dir_bits_r};
   wire [7:0] data_rd_val = mode ? in_latch_r : pin_latch_r;
   wire [7:0] rd_mux = hit_data ? data_rd_val :
                       // pins keep their own bit order: bit2 select, bit0 read strobe
                       hit_pins ? {5'h0, strobe_pin_val} :
                       hit_core ? core_irq_r :
                       hit_flags ? irq_flags_r :
                       hit_dir ? dir_status :
                       hit_ddir ? data_dir_r :
                       hit_en ? irq_en_r :
                       hit_adc ? {5'h0, analog_cfg_field_r} : 8'h00;

   // data pin drive: external strobes decide in port mode
   wire [7:0] oe_n_nxt = mode ? (rd_active ? 8'h00 : 8'hff) : data_dir_r; // RULE5 RULE13
   wire [7:0] dout_nxt = out_latch_r; // RULE4
   // direction 1 input, 0 output
   wire [2:0] soe_n_nxt = strobe_dir_bits_r; // RULE18

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= ACC_IDLE;
         end_pend_r <= 1'b0;
         end_q2_r <= 1'b0;
         end_write_r <= 1'b0;
      end else begin
         case (acc_r)
            ACC_IDLE: begin
               if (wr_start) begin
                  acc_r <= ACC_WRITE;
               end else if (rd_start) begin
                  acc_r <= ACC_READ;
               end
            end
            ACC_WRITE, ACC_READ: begin
               if (acc_end) begin
                  acc_r <= ACC_IDLE;
                  end_pend_r <= 1'b1;
                  end_write_r <= (acc_r == ACC_WRITE);
               end
            end
            default: acc_r <= ACC_IDLE;
         endcase
         if (end_pend_r & q2) begin
            end_pend_r <= 1'b0;
            end_q2_r <= 1'b1;
         end
         if (flag_evt) begin
            end_q2_r <= 1'b0;
         end
      end
   end

   // latch capture while write strobe is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_latch_r <= 8'h00;
         pin_latch_r <= 8'h00;
      end else begin
         pin_latch_r <= data_in;
         if (wr_active) begin
            in_latch_r <= data_in; // RULE4
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {psp_mode_select_r, strobe_dir_bits_r} <= 4'h7; // RULE19
         in_buf_full_r <= 1'b0;
         out_buf_full_r <= 1'b0;
         in_buf_overrun_r <= 1'b0;
      end else begin
         if (wr & hit_dir) begin
            psp_mode_select_r <= pwdata[`BIT_MODE];
            strobe_dir_bits_r <= pwdata[2:0];
         end
         // set wins over the software clear
         if (set_ovr) begin
            in_buf_overrun_r <= 1'b1; // RULE11
         end else if (wr & hit_dir & ~pwdata[`BIT_OVERRUN]) begin
            in_buf_overrun_r <= 1'b0; // RULE12
         end
         if (!mode) begin
            in_buf_full_r <= 1'b0; // RULE16
         end else if (set_ibf) begin
            in_buf_full_r <= 1'b1; // RULE8
         end else if (cpu_rd_data) begin
            in_buf_full_r <= 1'b0; // RULE10
         end
         if (!mode) begin
            out_buf_full_r <= 1'b0; // RULE16
         end else if (rd_start) begin
            out_buf_full_r <= 1'b0; // RULE13
         end else if (cpu_wr_data) begin
            out_buf_full_r <= 1'b1; // RULE15
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_latch_r <= 8'h00;
         strobe_latch_r <= 3'h0;
         data_dir_r <= `RST_DATA_DIR;
         irq_flags_r <= `RST_IRQ_FLAGS;
         irq_en_r <= `RST_IRQ_ENABLES;
         core_irq_r <= `RST_CORE_IRQ_CTRL;
         analog_cfg_field_r <= 3'(`RST_ANALOG_CFG);
      end else begin
         if (cpu_wr_data) begin
            out_latch_r <= pwdata[7:0]; // RULE4
         end
         if (wr & hit_pins) begin
            strobe_latch_r <= pwdata[2:0];
         end
         if (wr & hit_ddir) begin
            data_dir_r <= pwdata[7:0];
         end
         if (wr & hit_en) begin
            irq_en_r <= pwdata[7:0];
         end
         if (wr & hit_core) begin
            core_irq_r <= pwdata[7:0];
         end
         if (wr & hit_adc) begin
            analog_cfg_field_r <= pwdata[2:0];
         end
         if (wr & hit_flags) begin
            irq_flags_r <= pwdata[7:0];
         end
         // hardware set wins over a write of zero in the same cycle
         if (flag_evt) begin
            irq_flags_r[`BIT_PORT_IRQ] <= 1'b1; // RULE9 RULE14 RULE17
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         port_irq_r <= 1'b0;
         data_out_r <= 8'h00;
         data_oe_n_r <= 8'hff;
         strobe_out_r <= 3'h0;
         strobe_oe_n_r <= 3'h7;
      end else begin
         prdata_r <= (psel & ~penable & ~pwrite) ? {24'h0, rd_mux} : prdata_r;
         port_irq_r <= irq_flags_r[`BIT_PORT_IRQ] & irq_en_r[`BIT_PORT_IRQ]; // RULE17
         data_out_r <= dout_nxt;
         data_oe_n_r <= oe_n_nxt;
         strobe_out_r <= strobe_latch_r;
         strobe_oe_n_r <= soe_n_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign data_out = data_out_r;
   assign data_oe_n = data_oe_n_r;
   assign strobe_out = strobe_out_r;
   assign strobe_oe_n = strobe_oe_n_r;
   assign port_irq = port_irq_r;
endmodule : parallel_slave_port

/* File: verification/psp_asserts.sv */
// Purpose: port-level checks of the parallel slave port
// Assumes: strobe sync plus phase wait stay under 16 cycles
// Notes: bound from the bench top file
`timescale 1ns/10ps
module psp_asserts (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic [7:0] data_out,
   input wire logic [7:0] data_oe_n,
   input wire logic chip_select_pin,
   input wire logic [2:0] strobe_oe_n,
   input wire logic port_irq
);
   logic [4:0] act_r;
   logic en_r;
   wire logic wr_acc = psel && penable && pwrite;
   wire logic dir_wr = wr_acc && paddr == 32'h224;
   wire logic dat_wr = wr_acc && paddr == 32'h20;
   // saturates so a long idle never wraps back into range
   wire logic [4:0] act_nxt = (wr_acc || !chip_select_pin) ? 5'h00 :
      act_r + {4'h0, act_r != 5'h1f};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_r <= 5'h00;
         en_r <= 1'b0;
      end else begin
         act_r <= act_nxt;
         en_r <= (wr_acc && paddr == 32'h230) ? pwdata[7] : en_r;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_mask_wr;
      wr_acc && paddr == 32'h230 && !pwdata[7];
   endsequence
   AST_RESET_OE: assert property ($rose(presetn) |-> data_oe_n == 8'hff && strobe_oe_n == 3'h7)
      else $error("pin enables not at reset values");
   AST_DIR_OE: assert property (!$stable(strobe_oe_n) |-> $past(dir_wr) || $past(dir_wr, 2))
      else $error("strobe enables moved without a direction write");
   AST_OUT_LATCH: assert property (!$stable(data_out) |-> $past(dat_wr) || $past(dat_wr, 2))
      else $error("out latch moved without a cpu write");
   AST_IRQ_CAUSE: assert property ($rose(port_irq) |-> en_r && act_r <= 5'h10)
      else $error("irq rose without enable or access");
   AST_IRQ_MASK: assert property (s_mask_wr |-> ##2 !port_irq)
      else $error("irq still up after mask");
   AST_IRQ_HOLD: assert property ($fell(port_irq) |-> $past(wr_acc, 2) || $past(wr_acc, 3))
      else $error("irq dropped without software");
   AST_READ_DRIVE: assert property ($fell(data_oe_n[0]) |-> act_r <= 5'h08)
      else $error("data pins driven without cause");
   AST_ZERO_WAIT: assert property (psel && penable |-> pready && !pslverr)
      else $error("apb wait or error seen");
endmodule : psp_asserts

/* File: verification/ext_master.sv */
// Purpose: external 8-bit bus master on the strobe and data pins
// Assumes: strobes idle high; data floats after its hold time
// Notes: strobe pins in gpio output mode show the device drive; data pins show it only when all eight are outputs
`timescale 1ns/10ps
module ext_master
   import psp_pkg::*;
(
   // clock
   input wire logic pclk,
   // device pins
   input wire logic [7:0] data_out,
   input wire logic [7:0] data_oe_n,
   input wire logic [2:0] strobe_out,
   input wire logic [2:0] strobe_oe_n,
   output logic [7:0] data_in,
   output logic read_strobe_pin,
   output logic write_strobe_pin,
   output logic chip_select_pin
);
   strobe_t drv = '1;
   logic [7:0] bus_d = 8'h00;
   logic bus_en = 1'b0;
   logic [7:0] last_r = 8'h00;
   // floating bus moves every cycle so a stale byte never passes
   assign data_in = (data_oe_n == 8'h00) ? data_out : (bus_en ? bus_d : ~last_r);
   assign chip_select_pin = strobe_oe_n[2] ? drv.cs_n : strobe_out[2];
   assign write_strobe_pin = strobe_oe_n[1] ? drv.wr_n : strobe_out[1];
   assign read_strobe_pin = strobe_oe_n[0] ? drv.rd_n : strobe_out[0];
   always @(posedge pclk) begin
      last_r <= data_in;
   end
   // hold sets the low time, the idle gap and the data hold
   task automatic access(input logic wr, input logic [7:0] d, input int hold,
      output logic [7:0] q);
      @(posedge pclk);
      drv <= {1'b0, !wr, wr};
      bus_d <= d;
      bus_en <= wr;
      repeat (hold) @(posedge pclk);
      q = data_in;
      drv <= '1;
      repeat (hold) @(posedge pclk);
      bus_en <= 1'b0;
   endtask : access
endmodule : ext_master

/* File: verification/parallel_slave_port_test.sv */
// Purpose: self-checking bench of the parallel slave port
// Assumes: byte address is four times the register index
// Notes: far bus played by ext_master
`timescale 1ns/10ps
module parallel_slave_port_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, port_irq;
   logic [7:0] data_in, data_out, data_oe_n, b;
   logic read_strobe_pin, write_strobe_pin, chip_select_pin;
   logic [2:0] strobe_out, strobe_oe_n;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   parallel_slave_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .data_in, .data_out, .data_oe_n, .read_strobe_pin,
      .write_strobe_pin, .chip_select_pin, .strobe_out, .strobe_oe_n, .port_irq);
   ext_master ext (.pclk, .data_out, .data_oe_n, .strobe_out, .strobe_oe_n, .data_in,
      .read_strobe_pin, .write_strobe_pin, .chip_select_pin);
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errors = errors + 1;
         test_done();
      end
   end
   task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic rd(input logic [31:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check($sformatf("reg %h", a), {24'h0, exp}, q);
   endtask : rd
   // status lags the strobes, so poll under a bound
   task automatic poll(input logic [31:0] a, input logic [7:0] m);
      q = 32'h0;
      for (int n = 0; n < 40 && (q[7:0] & m) == 8'h00; n++) apb(1'b0, a, 8'h00);
   endtask : poll
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   task automatic test_done();
      $display("checks %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(32'h224, 8'h07);
      rd(32'h40, 8'h00);
      // select driven high so no phantom access starts when the port mode turns on
      apb(1'b1, 32'h24, 8'h06);
      apb(1'b1, 32'h224, 8'h02);
      apb(1'b1, 32'h220, 8'h00);
      settle();
      check("strobe_oe_n", 32'h2, {29'h0, strobe_oe_n});
      check("data_oe_n", 32'h0, {24'h0, data_oe_n});
      check("strobe_out", 32'h6, {29'h0, strobe_out});
      apb(1'b1, 32'h27c, 8'h07);
      apb(1'b1, 32'h224, 8'h17);
      apb(1'b1, 32'h230, 8'h80);
      settle();
      check("data_oe_n", 32'hff, {24'h0, data_oe_n});
      rd(32'h24, 8'h07);
      rd(32'h224, 8'h17);
      ext.access(1'b1, 8'h5a, 4, b);
      poll(32'h224, 8'h80);
      check("status", 32'h97, q);
      settle();
      check("port_irq", 32'h1, {31'h0, port_irq});
      ext.access(1'b1, 8'ha5, 8, b);
      poll(32'h224, 8'h20);
      check("status", 32'hb7, q);
      rd(32'h20, 8'ha5);
      rd(32'h224, 8'h37);
      apb(1'b1, 32'h30, 8'h00);
      apb(1'b1, 32'h230, 8'h00);
      settle();
      check("port_irq", 32'h0, {31'h0, port_irq});
      apb(1'b1, 32'h224, 8'h17);
      apb(1'b1, 32'h20, 8'h3c);
      rd(32'h224, 8'h57);
      ext.access(1'b0, 8'h00, 10, b);
      check("ext read", 32'h3c, {24'h0, b});
      poll(32'h30, 8'h80);
      check("flags", 32'h80, q);
      rd(32'h224, 8'h17);
      check("port_irq", 32'h0, {31'h0, port_irq});
      ext.access(1'b1, 8'h11, 4, b);
      poll(32'h224, 8'h80);
      ext.access(1'b1, 8'h22, 4, b);
      poll(32'h224, 8'h20);
      apb(1'b1, 32'h224, 8'h27);
      rd(32'h224, 8'h27);
      test_done();
   end
endmodule : parallel_slave_port_test
bind parallel_slave_port psp_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .data_out, .data_oe_n, .chip_select_pin, .strobe_oe_n,
   .port_irq);
